/* File: src/trig_pkg.sv */
// Constants and types shared by the hardware frame start trigger block
package trig_pkg;

   // Clock and timebase
   localparam int CLK_FREQ_MHZ = 250;
   localparam int TIMEBASE_US  = 1;
   localparam int TICK_CYCLES  = CLK_FREQ_MHZ * TIMEBASE_US;

   // Field widths
   localparam int TICK_W  = 8;
   localparam int DELAY_W = 24;
   localparam int EXP_W   = 32;

   // Delay range in microseconds
   localparam logic [DELAY_W-1:0] TRIG_DELAY_MAX_US = 24'h989680;
   localparam logic [DELAY_W-1:0] TRIG_DELAY_NONE   = 24'h000000;

   // Reset values
   localparam logic WAIT_RST = 1'b1;

   typedef enum logic [2:0] {
      SRC_LINE1,
      SRC_CC1,
      SRC_CC2,
      SRC_CC3,
      SRC_SOFTWARE
   } trig_src_t;

   typedef enum logic {
      EXP_TIMED,
      EXP_WIDTH
   } exp_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_DELAY,
      ST_EXPOSE
   } fsm_t;

   // Raw trigger inputs from the connector
   typedef struct packed {
      logic line1;
      logic cc1;
      logic cc2;
      logic cc3;
   } trig_pins_t;

   // Configuration held by the camera control logic
   typedef struct packed {
      logic               trig_on;
      trig_src_t          source;
      logic               falling;
      exp_mode_t          mode;
      logic [EXP_W-1:0]   exposure_raw;
      logic [EXP_W-1:0]   overlap_raw;
      logic [DELAY_W-1:0] delay_raw;
   } trig_cfg_t;

   // Status toward the rest of the camera
   typedef struct packed {
      logic wait_ready;
      logic exposing;
      logic frame_start;
      logic exposure_end;
      logic over_trigger;
   } trig_stat_t;

   // Synchroniser state
   typedef struct packed {
      trig_pins_t meta;
      trig_pins_t sync;
   } sync_state_t;

   // Trigger controller state
   typedef struct packed {
      fsm_t               state;
      logic               prev;
      logic               end_pend;
      logic [TICK_W-1:0]  tick;
      logic [DELAY_W-1:0] delay_cnt;
      logic [EXP_W-1:0]   elapsed;
      logic               width;
      trig_stat_t         stat;
   } trig_state_t;

endpackage

/* File: src/trig_pin_sync.sv */
// Two-stage synchroniser for the external trigger pins
`timescale 1ns/10ps
module trig_pin_sync (
   input  wire logic                ref_clk,  // Core clock
   input  wire logic                rst_n,    // Async reset, active low
   input  wire trig_pkg::trig_pins_t pins_in, // Raw pins
   output      trig_pkg::trig_pins_t pins_out // Synchronised pins
);
   import trig_pkg::*;

   sync_state_t st_r;
   sync_state_t st_nxt;

   // Meta stage feeds only the second stage
   always_comb begin
      st_nxt      = st_r;
      st_nxt.meta = pins_in;
      st_nxt.sync = st_r.meta;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pins_out = st_r.sync;

endmodule // trig_pin_sync

/* File: src/hw_frame_start_trigger.sv */
// Hardware frame start trigger controller with delay and exposure modes
`timescale 1ns/10ps
module hw_frame_start_trigger (
   input  wire logic                ref_clk,    // Core clock, 250 MHz
   input  wire logic                rst_n,      // Async reset, active low
   input  wire trig_pkg::trig_pins_t pins,      // Line 1 and CC1..CC3
   input  wire logic                sw_trigger, // Software trigger pulse
   input  wire trig_pkg::trig_cfg_t cfg,        // Static configuration
   output      trig_pkg::trig_stat_t stat       // Registered status
);
   import trig_pkg::*;

   // Synchronised pins and controller state
   trig_pins_t         pins_s;
   trig_state_t        st_r;
   trig_state_t        st_nxt;

   // Selected level and its edges
   logic               sel_lvl;
   logic               rise;
   logic               fall;
   logic               act_edge;
   logic               inact_edge;

   // Events, strobes and the legal delay
   logic               hw_src;
   logic               hw_evt;
   logic               sw_evt;
   logic               evt;
   logic               tick;
   logic               done;
   logic [DELAY_W-1:0] delay_us;

   // One microsecond tick from the core clock
   function automatic logic us_tick(input logic [TICK_W-1:0] cnt);
      us_tick = (cnt == TICK_W'(TICK_CYCLES - 1));
   endfunction

   // Delay above the legal range is held at the maximum
   // Larger settings would only stretch the wait
   function automatic logic [DELAY_W-1:0] clamp_delay(
      input logic [DELAY_W-1:0] raw);
      if (raw > TRIG_DELAY_MAX_US) begin
         clamp_delay = TRIG_DELAY_MAX_US;
      end else begin
         clamp_delay = raw;
      end
   endfunction

   // Start of one exposure; pending end is left to the caller
   function automatic trig_state_t begin_exposure(input trig_state_t s,
                                                  input logic w);
      trig_state_t r;
      r                  = s;
      r.state            = ST_EXPOSE;
      r.stat.exposing    = 1'b1;
      r.stat.frame_start = 1'b1;
      r.stat.wait_ready  = 1'b0;
      r.elapsed          = '0;
      // Prescaler restarts so the first microsecond is whole
      r.tick             = '0;
      r.width            = w;
      begin_exposure     = r;
   endfunction

   // Back to waiting; one-cycle pulses are left to the caller
   function automatic trig_state_t return_idle(input trig_state_t s);
      trig_state_t r;
      r                 = s;
      r.state           = ST_IDLE;
      r.stat.exposing   = 1'b0;
      r.stat.wait_ready = 1'b1;
      r.end_pend        = 1'b0;
      r.delay_cnt       = '0;
      return_idle       = r;
   endfunction

   // Width mode decode, shared by the delay and start paths
   function automatic logic is_width(input exp_mode_t m);
      is_width = (m == EXP_WIDTH);
   endfunction

   // Two flops on every pin before any edge logic
   trig_pin_sync u_sync (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .pins_in  (pins),
      .pins_out (pins_s)
   );

   // Source select; line 1 assumed already set as an input
   // Unused source codes read as a quiet low level
   always_comb begin
      unique case (cfg.source)
         SRC_LINE1: sel_lvl = pins_s.line1;
         SRC_CC1:   sel_lvl = pins_s.cc1;
         SRC_CC2:   sel_lvl = pins_s.cc2;
         SRC_CC3:   sel_lvl = pins_s.cc3;
         default:   sel_lvl = 1'b0;
      endcase
   end

   // Edge detection on the synchronised level
   // A pin change shows up as an edge two clocks later
   // Switching between pins at unequal levels looks like an edge
   assign rise       = sel_lvl & ~st_r.prev;
   assign fall       = ~sel_lvl & st_r.prev;
   assign act_edge   = cfg.falling ? fall : rise;
   assign inact_edge = cfg.falling ? rise : fall;

   // Trigger events; software needs no pin edge
   // Software pulses bypass the pins and the synchroniser
   assign hw_src = (cfg.source != SRC_SOFTWARE);
   assign hw_evt = cfg.trig_on & hw_src & act_edge;
   assign sw_evt = cfg.trig_on & ~hw_src & sw_trigger;
   assign evt    = hw_evt | sw_evt;
   assign tick   = us_tick(st_r.tick);

   // Legal delay, clamped once for both uses
   assign delay_us = clamp_delay(cfg.delay_raw);

   // Exposure end: count in timed mode, opposite edge in width mode
   // An opposite edge seen during the delay is kept in end_pend
   always_comb begin
      if (st_r.width) begin
         done = inact_edge | st_r.end_pend;
      end else begin
         done = (st_r.elapsed >= cfg.exposure_raw);
      end
   end

   // Main controller
   // Idle: ready shown, waits for an enabled event
   // Delay: whole microseconds counted, ready low
   // Expose: timed count or opposite edge ends it
   // Events outside idle are dropped and only flagged
   always_comb begin
      st_nxt                   = st_r;
      st_nxt.prev              = sel_lvl;
      // Status pulses last a single cycle
      st_nxt.stat.frame_start  = 1'b0;
      st_nxt.stat.exposure_end = 1'b0;
      st_nxt.stat.over_trigger = 1'b0;
      // Prescaler runs freely; starts and delays restart it
      st_nxt.tick              = tick ? '0 : TICK_W'(st_r.tick + 1'b1);
      unique case (st_r.state)
         ST_IDLE: begin
            if (evt) begin
               // Software source has timed exposure and no delay
               if (hw_evt && (delay_us != TRIG_DELAY_NONE)) begin
                  st_nxt.state     = ST_DELAY;
                  st_nxt.delay_cnt = delay_us;
                  st_nxt.tick      = '0;
                  st_nxt.stat.wait_ready = 1'b0;
                  // Mode taken at the trigger, not when the delay ends
                  st_nxt.width     = is_width(cfg.mode);
               end else begin
                  st_nxt = begin_exposure(st_nxt,
                     hw_src & is_width(cfg.mode));
               end
               st_nxt.end_pend = 1'b0;
            end
         end

         ST_DELAY: begin
            // Trigger during the delay is lost but flagged
            if (evt) begin
               st_nxt.stat.over_trigger = 1'b1;
            end
            // Width pulse ending early still closes the exposure
            if (st_r.width && inact_edge) begin
               st_nxt.end_pend = 1'b1;
            end
            // Dropping the enable abandons the pending start
            if (!cfg.trig_on) begin
               st_nxt = return_idle(st_nxt);
            end else if (tick) begin
               if (st_r.delay_cnt == DELAY_W'(1)) begin
                  st_nxt = begin_exposure(st_nxt, st_r.width);
               end else begin
                  st_nxt.delay_cnt = DELAY_W'(st_r.delay_cnt - 1'b1);
               end
            end
         end

         ST_EXPOSE: begin
            // Trigger during exposure is lost but flagged
            if (evt) begin
               st_nxt.stat.over_trigger = 1'b1;
            end
            // Elapsed time saturates rather than wrapping
            if (tick && (st_r.elapsed != '1)) begin
               st_nxt.elapsed = EXP_W'(st_r.elapsed + 1'b1);
            end
            // Ready may return before a long pulse has ended
            if (st_r.width && (st_r.elapsed >= cfg.overlap_raw)) begin
               st_nxt.stat.wait_ready = 1'b1;
            end
            if (done) begin
               st_nxt                   = return_idle(st_nxt);
               st_nxt.stat.exposure_end = 1'b1;
            end
         end

         // Unused state code falls back to waiting
         default: begin
            st_nxt = return_idle(st_nxt);
         end
      endcase
   end

   // State register
   // Ready starts high: nothing is pending out of reset
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r                 <= '0;
         st_r.state           <= ST_IDLE;
         st_r.stat.wait_ready <= WAIT_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign stat = st_r.stat;

endmodule // hw_frame_start_trigger

/* File: dv/trig_checker.sv */
// Port timing checks of the frame start trigger block
`timescale 1ns/10ps
module trig_checker (
   input wire logic                 ref_clk,    // Core clock
   input wire logic                 rst_n,      // Async reset
   input wire trig_pkg::trig_pins_t pins,       // Raw pins
   input wire logic                 sw_trigger, // Software pulse
   input wire trig_pkg::trig_cfg_t  cfg,        // Configuration
   input wire trig_pkg::trig_stat_t stat        // Status
);
   import trig_pkg::*;
   logic lvl;
   int   cyc_r;
   int   e_us;
   int   o_us;
   // Level of the selected pin
   always_comb begin
      case (cfg.source)
         SRC_LINE1: lvl = pins.line1;
         SRC_CC1:   lvl = pins.cc1;
         SRC_CC2:   lvl = pins.cc2;
         default:   lvl = pins.cc3;
      endcase
   end
   assign e_us = int'(cfg.exposure_raw);
   assign o_us = int'(cfg.overlap_raw);
   // Cycles since the last frame start
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         cyc_r <= 0;
      else
         cyc_r <= stat.frame_start ? 1 : cyc_r + 1;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Bounds allow for the free-running microsecond tick phase
   a_start_clr_ready: assert property (
      stat.frame_start |-> !stat.wait_ready && stat.exposing)
      else $error("ready not cleared at frame start");
   a_end_set_ready: assert property (
      stat.exposure_end |-> stat.wait_ready && !stat.exposing)
      else $error("ready not restored at exposure end");
   a_edge_starts: assert property (
      cfg.trig_on && cfg.source != SRC_SOFTWARE && cfg.delay_raw == 0 &&
      stat.wait_ready && !stat.exposing &&
      (cfg.falling ? $fell(lvl) : $rose(lvl)) |-> ##[2:5] stat.frame_start)
      else $error("active edge did not start a frame");
   a_timed_len: assert property (
      stat.exposure_end && cfg.mode == EXP_TIMED |->
      cyc_r > (e_us - 1) * TICK_CYCLES && cyc_r <= e_us * TICK_CYCLES + 3)
      else $error("timed exposure length wrong");
   a_width_end: assert property (
      cfg.mode == EXP_WIDTH && stat.exposing &&
      (cfg.falling ? $rose(lvl) : $fell(lvl)) |-> ##[2:5] stat.exposure_end)
      else $error("width exposure did not end");
   a_overlap_ready: assert property (
      cfg.mode == EXP_WIDTH && stat.exposing &&
      cyc_r == o_us * TICK_CYCLES + 3 |-> stat.wait_ready)
      else $error("ready not raised after overlap time");
   a_over_no_start: assert property (
      stat.over_trigger |-> !stat.frame_start && cfg.trig_on)
      else $error("over trigger with a frame start");
   a_off_quiet: assert property (
      !cfg.trig_on |-> !stat.frame_start && !stat.over_trigger)
      else $error("activity while triggering is off");
endmodule // trig_checker

bind hw_frame_start_trigger trig_checker chk (.ref_clk(ref_clk),
   .rst_n(rst_n), .pins(pins), .sw_trigger(sw_trigger), .cfg(cfg),
   .stat(stat));

/* File: dv/trig_source.sv */
// Model of the external device that drives the trigger pins
`timescale 1ns/10ps
module trig_source (
   input  wire logic                 ref_clk, // Core clock
   input  wire logic                 idle,    // Idle pin level
   input  wire logic [1:0]           sel,     // Pin to pulse
   input  wire logic                 go,      // Start a pulse
   input  wire logic [31:0]          wid,     // Pulse length in cycles
   output      trig_pkg::trig_pins_t pins     // Pins toward the camera
);
   int cnt = 0;
   // Pulse timer; the line is always an input on the camera side
   always @(posedge ref_clk) begin
      if (go)
         cnt <= wid;
      else if (cnt > 0)
         cnt <= cnt - 1;
   end
   assign pins = {4{idle}} ^ ((cnt > 0) ? (4'h8 >> sel) : 4'h0);
endmodule // trig_source

/* File: dv/tb_top.sv */
// Self-checking testbench of the frame start trigger block
`timescale 1ns/10ps
module tb_top;
   import trig_pkg::*;
   logic       ref_clk    = 0;
   logic       rst_n      = 0;
   logic       sw_trigger = 0;
   logic       go         = 0;
   logic       idle       = 0;
   logic [1:0] sel        = 0;
   int         wid        = 1;
   trig_cfg_t  cfg        = '0;
   trig_pins_t pins;
   trig_stat_t stat;
   int         failures   = 0;
   int         cmp_count  = 0;
   int         n_st       = 0;
   int         n_ov       = 0;
   int         n_en       = 0;
   int         t;
   hw_frame_start_trigger dut (.ref_clk(ref_clk), .rst_n(rst_n),
      .pins(pins), .sw_trigger(sw_trigger), .cfg(cfg), .stat(stat));
   trig_source src (.ref_clk(ref_clk), .idle(idle), .sel(sel), .go(go),
      .wid(wid), .pins(pins));
   always #2 ref_clk = ~ref_clk;
   // Pulse counts, taken on the falling edge to stay clear of updates
   always @(negedge ref_clk) begin
      n_st += stat.frame_start;
      n_ov += stat.over_trigger;
      n_en += stat.exposure_end;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // Configuration change, then time for the synchroniser to settle
   task automatic setup(input logic on, input trig_src_t s,
                        input exp_mode_t m, input logic [23:0] d);
      // Overlap of 1 us is just under the 300-cycle width pulse used
      cfg <= '{on, s, idle, m, 32'h2, 32'h1, d};
      cyc(8);
   endtask
   // Pulses, then compare starts and over-triggers seen meanwhile
   task automatic shot(input logic [1:0] s, input int w, input int gap,
                       input int es, input int eo);
      int a;
      int b;
      a = n_st;
      b = n_ov;
      sel <= s;
      wid <= w;
      go <= 1;
      cyc(1);
      go <= 0;
      cyc(gap);
      chk(n_st - a, es);
      chk(n_ov - b, eo);
   endtask
   task automatic end_of_test;
      $display("Compares %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Watchdog well beyond the expected run of about 40 us
   initial begin
      #100000;
      failures++;
      end_of_test;
   end
   // Main sequence
   initial begin
      cyc(4);
      rst_n <= 1;
      cyc(1);
      chk({27'h0, stat}, 32'h10);
      $display("Test reset done");
      for (int f = 0; f < 2; f++) begin
         idle <= f[0];
         setup(0, SRC_CC1, EXP_TIMED, 24'h0);
         for (int s = 0; s < 4; s++) begin
            setup(1, trig_src_t'(s), EXP_TIMED, 24'h0);
            shot(s[1:0], 20, 600, 1, 0);
         end
         // Back to back on the last source selected, CC3
         shot(3, 20, 100, 1, 0);
         shot(3, 20, 600, 0, 1);
         shot(3, 20, 600, 1, 0);
         setup(1, SRC_CC2, EXP_WIDTH, 24'h0);
         shot(2, 300, 150, 1, 0);
         chk(stat.wait_ready, 0);
         cyc(120);
         chk({stat.exposing, stat.wait_ready}, 2'h3);
         cyc(200);
         chk(stat.exposing, 0);
         $display("Test edge polarity done");
      end
      setup(1, SRC_CC3, EXP_TIMED, 24'h1);
      shot(3, 20, 0, 0, 0);
      for (t = 1; t < 400 && stat.frame_start !== 1'b1; t++)
         cyc(1);
      chk(t >= 250 && t <= 262, 1);
      cyc(700);
      setup(1, SRC_SOFTWARE, EXP_TIMED, 24'h1);
      sw_trigger <= 1;
      cyc(1);
      sw_trigger <= 0;
      cyc(3);
      chk(stat.exposing, 1);
      cyc(600);
      setup(0, SRC_CC1, EXP_TIMED, 24'h0);
      shot(1, 20, 50, 0, 0);
      chk(stat.wait_ready, 1);
      // Seven starts per polarity, one delayed, one software
      chk(n_st, 16);
      chk(n_en, 16);
      $display("Test delay and software done");
      end_of_test;
   end
endmodule // tb_top
